// ==== common/fruo_defs.vh ====
// Purpose: shared constants for the file-register unary datapath
// Assumes: 8-bit data, 32 file registers, wishbone register window
// Notes:   offsets are byte addresses of 32-bit words
`ifndef FRUO_DEFS_VH
`define FRUO_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FRUO_OFF_CMD      6'h00
`define FRUO_OFF_ACC      6'h04
`define FRUO_OFF_STAT     6'h08
`define FRUO_OFF_WDOG     6'h0C
`define FRUO_OFF_FADDR    6'h10
`define FRUO_OFF_FDATA    6'h14
`define FRUO_OFF_CFG      6'h18

// ----------------------------------------------------------------
// command field layout
// ----------------------------------------------------------------
`define FRUO_CMD_FA_LSB   0
`define FRUO_CMD_FA_MSB   4
`define FRUO_CMD_DEST     5
`define FRUO_CMD_OP_LSB   8
`define FRUO_CMD_OP_MSB   10

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define FRUO_OP_NOP       3'h0
`define FRUO_OP_KICK      3'h1
`define FRUO_OP_CLEAR     3'h2
`define FRUO_OP_INVERT    3'h3
`define FRUO_OP_MINUS     3'h4
`define FRUO_OP_PLUS      3'h5
`define FRUO_OP_DNSKIP    3'h6
`define FRUO_OP_UPSKIP    3'h7

// ----------------------------------------------------------------
// status bits and reset values
// ----------------------------------------------------------------
`define FRUO_ST_ZERO      0
`define FRUO_ST_SLEEP_N   3
`define FRUO_ST_EXPIRY_N  4
`define FRUO_ST_BUSY      7
`define FRUO_ACC_RST      8'h00
`define FRUO_FILE_RST     8'h00
`define FRUO_WDOG_ZERO    8'h00
`define FRUO_PRE_ZERO     8'h00

`endif

// ==== logic/fruo_file_mem.v ====
// Purpose: 32 x 8 file register memory, registered read
// Assumes: one write port, two read ports
// Notes:   read data appear one cycle after the address
`timescale 1ns/1ps
module fruo_file_mem #(
  parameter AW = 5,
  parameter DW = 8
) (
  // clock
  input  wire          clk_i,
  // write port
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  // read ports
  input  wire [AW-1:0] raddr_a_i,
  output reg  [DW-1:0] rdata_a_o,
  input  wire [AW-1:0] raddr_b_i,
  output reg  [DW-1:0] rdata_b_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_a_o <= mem[raddr_a_i];
    rdata_b_o <= mem[raddr_b_i];
  end

endmodule

// ==== logic/fruo_core.v ====
// Purpose: executes the watchdog-kick and file-register unary operations
// Assumes: one clk_i cycle per instruction phase; wishbone classic slave
// Notes:   operation is issued by writing the command register
//
// Notes on behaviour
// - kick loads watchdog counter with zero
// - kick clears prescaler only if watchdog-assigned
// - kick sets expiry and sleep flags, nothing else
// - file clear writes zero, sets zero flag
// - file address 0..31, destination bit 0/1
// - destination zero accumulator, one file register
// - invert: bitwise inverse, updates zero flag
// - minus one: decrement, updates zero flag
// - plus one: 8-bit wrapping increment, zero flag
// - count-down skip: decrement, skip on zero
// - count-up skip: increment, skip on wrap
// - skip discards prefetch, runs nop, three cycles
`timescale 1ns/1ps
`include "fruo_defs.vh"
module fruo_core #(
  parameter AW = 5,
  parameter DW = 8
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          rst_i,
  // wishbone slave
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [5:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  // system side
  input  wire          pre_to_wdog_i,
  output reg           wdog_clear_o,
  output reg           pre_clear_o,
  output reg           skip_o,
  output reg           discard_fetch_o,
  output reg  [DW-1:0] watchdog_counter_o
);

  // ----------------------------------------------------------------
  // phases
  // ----------------------------------------------------------------
  localparam PH_IDLE = 2'h0;
  localparam PH_READ = 2'h1;
  localparam PH_EXEC = 2'h2;
  localparam PH_NOP  = 2'h3;

  reg  [1:0]    phase;
  reg  [2:0]    op;
  reg  [AW-1:0] faddr;
  reg           dest;
  reg  [DW-1:0] acc;
  reg           zero_flag;
  reg           expiry_flag_n;
  reg           sleep_flag_n;
  reg  [AW-1:0] dbg_addr;
  reg  [DW-1:0] prescaler;
  reg           cfg_pre_wdog;
  reg           pre_s1;
  reg           pre_s2;

  wire [DW-1:0] file_val;
  wire [DW-1:0] dbg_val;

  reg  [DW-1:0] next_result;
  reg           next_zero;
  reg           upd_zero;
  reg           do_skip;
  reg           mem_we;
  reg  [AW-1:0] mem_waddr;
  reg  [DW-1:0] mem_wdata;

  wire          bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire          bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  wire          busy    = (phase != PH_IDLE);

  function is_addr;
    input [5:0] a;
    input [5:0] off;
    begin
      is_addr = (a[5:2] == off[5:2]);
    end
  endfunction

  // ----------------------------------------------------------------
  // file memory
  // ----------------------------------------------------------------
  fruo_file_mem #(
    .AW (AW),
    .DW (DW)
  ) u_mem (
    .clk_i     (clk_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (mem_wdata),
    .raddr_a_i (faddr),
    .rdata_a_o (file_val),
    .raddr_b_i (dbg_addr),
    .rdata_b_o (dbg_val)
  );

  // ----------------------------------------------------------------
  // prescaler ownership strap, from another domain
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      pre_s1 <= 1'b0;
      pre_s2 <= 1'b0;
    end else begin
      pre_s1 <= pre_to_wdog_i;
      pre_s2 <= pre_s1;
    end
  end

  // ----------------------------------------------------------------
  // operation datapath
  // ----------------------------------------------------------------
  always @* begin
    next_result = file_val;
    next_zero   = zero_flag;
    upd_zero    = 1'b0;
    do_skip     = 1'b0;
    case (op)
      `FRUO_OP_CLEAR: begin
        next_result = `FRUO_FILE_RST;
        next_zero   = 1'b1;
        upd_zero    = 1'b1;
      end
      `FRUO_OP_INVERT: begin
        next_result = ~file_val;
        next_zero   = (next_result == 8'h00);
        upd_zero    = 1'b1;
      end
      `FRUO_OP_MINUS: begin
        next_result = file_val - 8'h01;
        next_zero   = (next_result == 8'h00);
        upd_zero    = 1'b1;
      end
      `FRUO_OP_PLUS: begin
        next_result = file_val + 8'h01;
        next_zero   = (next_result == 8'h00);
        upd_zero    = 1'b1;
      end
      `FRUO_OP_DNSKIP: begin
        next_result = file_val - 8'h01;
        do_skip     = (next_result == 8'h00);
      end
      `FRUO_OP_UPSKIP: begin
        next_result = file_val + 8'h01;
        do_skip     = (next_result == 8'h00);
      end
      default: begin
        next_result = file_val;
      end
    endcase
  end

  // memory write: execute phase has priority over software load
  always @* begin
    mem_we    = 1'b0;
    mem_waddr = dbg_addr;
    mem_wdata = wb_dat_i[7:0];
    if (phase == PH_EXEC && op != `FRUO_OP_KICK && op != `FRUO_OP_NOP) begin
      mem_waddr = faddr;
      mem_wdata = next_result;
      mem_we    = (op == `FRUO_OP_CLEAR) | dest;
    end else if (bus_wr && is_addr(wb_adr_i, `FRUO_OFF_FDATA) && !busy) begin
      mem_we    = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer, accumulator and flags
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      phase           <= PH_IDLE;
      op              <= `FRUO_OP_NOP;
      faddr           <= {AW{1'b0}};
      dest            <= 1'b0;
      acc             <= `FRUO_ACC_RST;
      zero_flag       <= 1'b0;
      expiry_flag_n   <= 1'b1;
      sleep_flag_n    <= 1'b1;
      dbg_addr        <= {AW{1'b0}};
      prescaler       <= `FRUO_PRE_ZERO;
      cfg_pre_wdog    <= 1'b0;
      watchdog_counter_o <= `FRUO_WDOG_ZERO;
      wdog_clear_o    <= 1'b0;
      pre_clear_o     <= 1'b0;
      skip_o          <= 1'b0;
      discard_fetch_o <= 1'b0;
    end else begin
      wdog_clear_o    <= 1'b0;
      pre_clear_o     <= 1'b0;
      skip_o          <= 1'b0;
      discard_fetch_o <= 1'b0;
      watchdog_counter_o <= watchdog_counter_o + 8'h01;
      prescaler       <= prescaler + 8'h01;
      case (phase)
        PH_IDLE: begin
          if (bus_wr && is_addr(wb_adr_i, `FRUO_OFF_CMD)) begin
            op    <= wb_dat_i[`FRUO_CMD_OP_MSB:`FRUO_CMD_OP_LSB];
            faddr <= wb_dat_i[`FRUO_CMD_FA_MSB:`FRUO_CMD_FA_LSB];
            dest  <= wb_dat_i[`FRUO_CMD_DEST];
            phase <= PH_READ;
          end
        end
        PH_READ: begin
          phase <= PH_EXEC;
        end
        PH_EXEC: begin
          phase <= PH_IDLE;
          if (op == `FRUO_OP_KICK) begin
            watchdog_counter_o <= `FRUO_WDOG_ZERO;
            wdog_clear_o       <= 1'b1;
            if (cfg_pre_wdog | pre_s2) begin
              prescaler   <= `FRUO_PRE_ZERO;
              pre_clear_o <= 1'b1;
            end
            expiry_flag_n <= 1'b1;
            sleep_flag_n  <= 1'b1;
          end else if (op != `FRUO_OP_NOP) begin
            if (!dest && op != `FRUO_OP_CLEAR) begin
              acc <= next_result;
            end
            if (upd_zero) begin
              zero_flag <= next_zero;
            end
            if (do_skip) begin
              skip_o          <= 1'b1;
              discard_fetch_o <= 1'b1;
              phase           <= PH_NOP;
            end
          end
        end
        PH_NOP: begin
          phase <= PH_IDLE;
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
      if (bus_wr && !busy) begin
        if (is_addr(wb_adr_i, `FRUO_OFF_ACC)) begin
          acc <= wb_dat_i[7:0];
        end
        if (is_addr(wb_adr_i, `FRUO_OFF_FADDR)) begin
          dbg_addr <= wb_dat_i[AW-1:0];
        end
        if (is_addr(wb_adr_i, `FRUO_OFF_CFG)) begin
          cfg_pre_wdog <= wb_dat_i[0];
        end
        if (is_addr(wb_adr_i, `FRUO_OFF_STAT)) begin
          zero_flag     <= wb_dat_i[`FRUO_ST_ZERO];
          sleep_flag_n  <= wb_dat_i[`FRUO_ST_SLEEP_N];
          expiry_flag_n <= wb_dat_i[`FRUO_ST_EXPIRY_N];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // wishbone answer, one cycle after request
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_req && !wb_we_i) begin
        if (is_addr(wb_adr_i, `FRUO_OFF_CMD)) begin
          wb_dat_o <= {21'h000000, op, 2'h0, dest, faddr};
        end else if (is_addr(wb_adr_i, `FRUO_OFF_ACC)) begin
          wb_dat_o <= {24'h000000, acc};
        end else if (is_addr(wb_adr_i, `FRUO_OFF_STAT)) begin
          wb_dat_o <= {24'h000000, busy, 2'h0, expiry_flag_n, sleep_flag_n,
                       2'h0, zero_flag};
        end else if (is_addr(wb_adr_i, `FRUO_OFF_WDOG)) begin
          wb_dat_o <= {16'h0000, prescaler, watchdog_counter_o};
        end else if (is_addr(wb_adr_i, `FRUO_OFF_FADDR)) begin
          wb_dat_o <= {27'h0000000, dbg_addr};
        end else if (is_addr(wb_adr_i, `FRUO_OFF_FDATA)) begin
          wb_dat_o <= {24'h000000, dbg_val};
        end else if (is_addr(wb_adr_i, `FRUO_OFF_CFG)) begin
          wb_dat_o <= {31'h00000000, cfg_pre_wdog};
        end
      end
    end
  end

endmodule

// ==== tb/fruo_core_monitor.sv ====
// Purpose: port checks of fruo_core
// Assumes: command results three edges after the taking edge
// Notes:   attached to every fruo_core by the bind below
`timescale 1ns/1ps
`include "fruo_defs.vh"
module fruo_core_monitor #(
  parameter AW = 5,
  parameter DW = 8
) (
  // clock and reset
  input wire          clk_i,
  input wire          rst_i,
  // bus
  input wire          wb_cyc_i,
  input wire          wb_stb_i,
  input wire          wb_we_i,
  input wire [5:0]    wb_adr_i,
  input wire          wb_ack_o,
  // system side
  input wire          wdog_clear_o,
  input wire          pre_clear_o,
  input wire          skip_o,
  input wire          discard_fetch_o,
  input wire [DW-1:0] watchdog_counter_o
);
  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire cmd = req && wb_we_i && wb_adr_i == `FRUO_OFF_CMD;
  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  kick_zero_a: assert property (wdog_clear_o |-> watchdog_counter_o == 0)
    else $error("counter not zero on kick");
  kick_count_a: assert property (wdog_clear_o |=> watchdog_counter_o == 1)
    else $error("counter not restarted after kick");
  pre_with_kick_a: assert property (pre_clear_o |-> wdog_clear_o)
    else $error("prescaler clear without kick");
  kick_cause_a: assert property (wdog_clear_o |-> $past(cmd, 3))
    else $error("kick without command three edges before");
  skip_cause_a: assert property (skip_o |-> $past(cmd, 3))
    else $error("skip without command three edges before");
  discard_pair_a: assert property (skip_o == discard_fetch_o)
    else $error("discard differs from skip");
  skip_single_a: assert property (skip_o |=> !skip_o)
    else $error("skip longer than one cycle");
endmodule

bind fruo_core fruo_core_monitor #(.AW(AW), .DW(DW)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .wdog_clear_o(wdog_clear_o), .pre_clear_o(pre_clear_o), .skip_o(skip_o),
  .discard_fetch_o(discard_fetch_o), .watchdog_counter_o(watchdog_counter_o)
);

// ==== tb/file_register_unary_ops_bench.sv ====
// Purpose: random and corner run of fruo_core
// Assumes: classic wishbone single cycles, 100 MHz clock
// Notes:   file contents are set through the debug window
`timescale 1ns/1ps
`include "fruo_defs.vh"
module file_register_unary_ops_bench;
  // ------------------------------------------------
  // signals and model state
  // ------------------------------------------------
  reg         clk_i    = 1'b0;
  reg         rst_i    = 1'b1;
  reg         wb_cyc_i = 1'b0;
  reg         wb_stb_i = 1'b0;
  reg         wb_we_i  = 1'b0;
  reg  [5:0]  wb_adr_i = 6'h00;
  reg  [31:0] wb_dat_i = 32'h0;
  reg         pre_i    = 1'b0;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, wdog_clr, pre_clr, skip, discard;
  wire [7:0]  wdog_cnt;
  reg  [31:0] rd;
  reg  [7:0]  acc = 8'h00;
  reg  [7:0]  st, v, r;
  reg  [2:0]  op;
  reg  [4:0]  f;
  reg         d, cfg;
  integer     seed = 32'hC1CF;
  integer     mismatches = 0;
  integer     checked = 0;
  integer     nskip = 0;
  integer     npre = 0;
  integer     nkick = 0;
  integer     i, k0, p0, s0;

  always #5 clk_i = ~clk_i;

  fruo_core #(.AW(5), .DW(8)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pre_to_wdog_i(pre_i), .wdog_clear_o(wdog_clr), .pre_clear_o(pre_clr),
    .skip_o(skip), .discard_fetch_o(discard), .watchdog_counter_o(wdog_cnt)
  );

  always @(posedge clk_i) begin
    nskip = nskip + (skip === 1'b1);
    npre = npre + (pre_clr === 1'b1);
    nkick = nkick + (wdog_clr === 1'b1);
  end

  task report_and_stop;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task check(input [39:0] nm, input [31:0] s, input [31:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  task wb_acc(input [5:0] a, input w, input [31:0] dat);
    integer n;
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= dat;
      n = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk_i);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n == 20) begin
        mismatches = mismatches + 1;
        report_and_stop;
      end
    end
  endtask

  function [7:0] f_res(input [2:0] o, input [7:0] x);
    begin
      case (o)
        3'h2: f_res = 8'h00;
        3'h3: f_res = ~x;
        3'h4, 3'h6: f_res = x - 8'h01;
        3'h5, 3'h7: f_res = x + 8'h01;
        default: f_res = x;
      endcase
    end
  endfunction

  task run_op;
    integer n;
    begin
      pre_i <= $random(seed);
      cfg = $random(seed);
      st = $random(seed) & 8'h19;
      wb_acc(`FRUO_OFF_CFG, 1'b1, {31'h0, cfg});
      wb_acc(`FRUO_OFF_STAT, 1'b1, {24'h0, st});
      wb_acc(`FRUO_OFF_FADDR, 1'b1, {27'h0, f});
      wb_acc(`FRUO_OFF_FDATA, 1'b1, {24'h0, v});
      k0 = nkick;
      p0 = npre;
      s0 = nskip;
      wb_acc(`FRUO_OFF_CMD, 1'b1, {21'h0, op, 2'b00, d, f});
      n = 0;
      rd = 32'h80;
      while (rd[7] !== 1'b0 && n < 20) begin
        wb_acc(`FRUO_OFF_STAT, 1'b0, 32'h0);
        n = n + 1;
      end
      if (n == 20) begin
        mismatches = mismatches + 1;
        report_and_stop;
      end
      r = f_res(op, v);
      if (op > 3'h2 && !d) acc = r;
      if (op == 3'h1) st[4:3] = 2'b11;
      if (op >= 3'h2 && op <= 3'h5) st[0] = (r == 8'h00);
      check("stat", rd, {24'h0, st});
      wb_acc(`FRUO_OFF_ACC, 1'b0, 32'h0);
      check("acc", rd, {24'h0, acc});
      wb_acc(`FRUO_OFF_FDATA, 1'b0, 32'h0);
      check("file", rd, {24'h0, (op == 3'h2 || (op > 3'h2 && d)) ? r : v});
      check("skips", nskip - s0, op >= 3'h6 && r == 8'h00);
      check("kicks", nkick - k0, op == 3'h1);
      check("pre", npre - p0, op == 3'h1 && (cfg || pre_i));
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_acc(`FRUO_OFF_STAT, 1'b0, 32'h0);
    check("stat0", rd, 32'h18);
    wb_acc(6'h1C, 1'b1, 32'hFF);
    wb_acc(6'h1C, 1'b0, 32'h0);
    check("hole", rd, 32'h0);
    for (i = 0; i < 80; i = i + 1) begin
      op = i;
      d = $random(seed);
      f = (i % 7 == 0) ? 5'h1F : $random(seed);
      case (i % 5)
        0: v = 8'h00;
        1: v = 8'h01;
        2: v = 8'hFF;
        default: v = $random(seed);
      endcase
      run_op;
    end
    report_and_stop;
  end
endmodule
